// file: inc/rxbm_map.svh
// register offsets, field positions, reset values and fixed counts of the receive ring manager
// assumes inclusion by bare name from design and bench files
`ifndef RXBM_MAP_SVH
`define RXBM_MAP_SVH

// register port offsets (3-bit address, 8-bit data)
`define RXBM_OFS_RING_FIRST 3'h0
`define RXBM_OFS_RING_END 3'h1
`define RXBM_OFS_WRITE_PTR 3'h2
`define RXBM_OFS_BOUNDARY 3'h3
`define RXBM_OFS_CONFIG 3'h4
`define RXBM_OFS_STATUS 3'h5
`define RXBM_OFS_LAST_STAT 3'h6

// config fields
`define RXBM_CFG_ACC_RUNT 0
`define RXBM_CFG_ACC_ERR 1
// status fields
`define RXBM_STS_OVERFLOW 0
`define RXBM_STS_BUSY 1

// header status byte fields
`define RXBM_HS_GOOD 0
`define RXBM_HS_CRC 1
`define RXBM_HS_ALIGN 2
`define RXBM_HS_MII 3
`define RXBM_HS_RUNT 4
`define RXBM_HS_MCAST 5

// reset values
`define RXBM_RST_RING_FIRST 8'h46
`define RXBM_RST_RING_END 8'h80
`define RXBM_RST_WRITE_PTR 8'h47
`define RXBM_RST_BOUNDARY 8'h46
`define RXBM_RST_CONFIG 2'h0

// page geometry: 256 bytes per page, 4 bytes of header room
`define RXBM_HDR_ROOM 8'h04
`define RXBM_MEM_WORDS 8192
`define RXBM_WORD_AW 13

`endif

// file: inc/rxbm_pkg.sv
// types shared by the receive ring manager files
// assumes nothing from rxbm_map.svh; state codes are one-hot literals
package rxbm_pkg;

  typedef enum logic [4:0] {
    RXBM_IDLE = 5'h01,
    RXBM_RECV = 5'h02,
    RXBM_DROP = 5'h04,
    RXBM_HDR0 = 5'h08,
    RXBM_HDR1 = 5'h10
  } rxbm_state_t;

endpackage : rxbm_pkg

// file: hw/rxbm_mem.sv
// packet memory: one write port for the receive dma, one read port for the host side
// assumes a single clock; read data come from a register one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "rxbm_map.svh"

module rxbm_mem #(
  parameter int WORDS = `RXBM_MEM_WORDS,
  parameter int AW = `RXBM_WORD_AW
) (
  // clock
  input wire logic i_sys_clk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [15:0] i_wdata,
  // read port
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [15:0] o_rdata
);

  // no reset on the array so it maps onto block ram
  logic [15:0] mem [0:WORDS-1];

  always_ff @(posedge i_sys_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    if (i_re)
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : rxbm_mem

`default_nettype wire

// file: hw/rxbm_ring.sv
// receive ring manager: local dma writes of received frames into a paged ring
// assumes mac receive logic on the same clock and a host that advances the boundary
`timescale 1ns/1ps
`default_nettype none
`include "rxbm_map.svh"

module rxbm_ring #(
  parameter int AW = `RXBM_WORD_AW
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // mac receive stream
  input wire logic i_rx_start,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  input wire logic i_rx_runt,
  input wire logic i_rx_crc_err,
  input wire logic i_rx_align_err,
  input wire logic i_rx_mii_err,
  input wire logic i_rx_mcast,
  output logic o_rx_ready,
  // host memory read
  input wire logic i_host_rd,
  input wire logic [AW-1:0] i_host_word_addr,
  output logic [15:0] o_host_rdata,
  // frame events
  output logic o_frame_done,
  output logic o_frame_dropped
);

  typedef struct packed {
    rxbm_pkg::rxbm_state_t state;
    logic [7:0] ring_first;
    logic [7:0] ring_end;
    logic [7:0] rx_write_page_ptr;
    logic [7:0] boundary;
    logic acc_runt;
    logic acc_err;
    logic overflow;
    logic [7:0] last_status;
    logic [7:0] cur_page;
    logic [7:0] following_frame_page;
    logic [7:0] offset;
    logic need_link;
    logic have_low;
    logic [7:0] low_byte;
    logic [10:0] length;
    logic [7:0] hdr_status;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [7:0] rdata;
    logic done;
    logic dropped;
  } rxbm_regs_t;

  rxbm_regs_t r;
  rxbm_regs_t next_r;

  // page after p, folded back into the ring
  function automatic logic [7:0] ring_next(input logic [7:0] p, input logic [7:0] first,
                                           input logic [7:0] last);
    logic [7:0] inc;
    inc = p + 8'h01;
    ring_next = (inc == last) ? first : inc;
  endfunction : ring_next

  // word address of a byte inside the packet memory
  function automatic logic [AW-1:0] word_of(input logic [7:0] page, input logic [7:0] ofs);
    logic [15:0] byte_addr;
    byte_addr = {page, ofs};
    word_of = byte_addr[AW:1];
  endfunction : word_of

  logic reject;
  logic [7:0] link_page;
  logic [7:0] stat_byte;

  // status byte as it will sit in the header, bits 7:6 held at zero
  always_comb
  begin
    stat_byte = 8'h00;
    stat_byte[`RXBM_HS_MCAST] = i_rx_mcast;
    stat_byte[`RXBM_HS_RUNT] = i_rx_runt;
    stat_byte[`RXBM_HS_MII] = i_rx_mii_err;
    stat_byte[`RXBM_HS_ALIGN] = i_rx_align_err;
    stat_byte[`RXBM_HS_CRC] = i_rx_crc_err;
    stat_byte[`RXBM_HS_GOOD] = ~(i_rx_runt | i_rx_mii_err | i_rx_align_err | i_rx_crc_err);
  end

  // runt, crc and align faults are rejected unless config lets them through; mii errors never reject
  assign reject = (i_rx_runt & ~r.acc_runt) |
                  ((i_rx_crc_err | i_rx_align_err) & ~r.acc_err);
  assign link_page = ring_next(r.cur_page, r.ring_first, r.ring_end);

  always_comb
  begin
    next_r = r;
    next_r.mem_we = 1'b0;
    next_r.done = 1'b0;
    next_r.dropped = 1'b0;
    // scratch pointer kept current so end of frame costs no extra cycle
    next_r.following_frame_page = link_page;

    // register writes; ring pointers are only safe to move while idle
    if (i_reg_wr)
    begin
      if (i_reg_addr == `RXBM_OFS_RING_FIRST)
      begin
        next_r.ring_first = i_reg_wdata;
      end
      else if (i_reg_addr == `RXBM_OFS_RING_END)
      begin
        next_r.ring_end = i_reg_wdata;
      end
      else if (i_reg_addr == `RXBM_OFS_WRITE_PTR)
      begin
        next_r.rx_write_page_ptr = i_reg_wdata;
      end
      else if (i_reg_addr == `RXBM_OFS_BOUNDARY)
      begin
        next_r.boundary = i_reg_wdata;
      end
      else if (i_reg_addr == `RXBM_OFS_CONFIG)
      begin
        next_r.acc_runt = i_reg_wdata[`RXBM_CFG_ACC_RUNT];
        next_r.acc_err = i_reg_wdata[`RXBM_CFG_ACC_ERR];
      end
      else if (i_reg_addr == `RXBM_OFS_STATUS)
      begin
        // write one to clear
        if (i_reg_wdata[`RXBM_STS_OVERFLOW])
        begin
          next_r.overflow = 1'b0;
        end
      end
    end

    // register reads, answer in the following cycle
    next_r.rdata = 8'h00;
    if (i_reg_rd)
    begin
      if (i_reg_addr == `RXBM_OFS_RING_FIRST)
      begin
        next_r.rdata = r.ring_first;
      end
      else if (i_reg_addr == `RXBM_OFS_RING_END)
      begin
        next_r.rdata = r.ring_end;
      end
      else if (i_reg_addr == `RXBM_OFS_WRITE_PTR)
      begin
        next_r.rdata = r.rx_write_page_ptr;
      end
      else if (i_reg_addr == `RXBM_OFS_BOUNDARY)
      begin
        next_r.rdata = r.boundary;
      end
      else if (i_reg_addr == `RXBM_OFS_CONFIG)
      begin
        next_r.rdata = {6'h00, r.acc_err, r.acc_runt};
      end
      else if (i_reg_addr == `RXBM_OFS_STATUS)
      begin
        next_r.rdata = {6'h00, (r.state != rxbm_pkg::RXBM_IDLE), r.overflow};
      end
      else if (i_reg_addr == `RXBM_OFS_LAST_STAT)
      begin
        next_r.rdata = r.last_status;
      end
    end

    case (r.state)
      rxbm_pkg::RXBM_IDLE:
      begin
        if (i_rx_start)
        begin
          next_r.state = rxbm_pkg::RXBM_RECV;
          next_r.cur_page = r.rx_write_page_ptr;
          next_r.offset = `RXBM_HDR_ROOM;
          next_r.need_link = 1'b0;
          next_r.have_low = 1'b0;
          next_r.length = 11'h000;
        end
      end
      rxbm_pkg::RXBM_RECV:
      begin
        if (i_rx_valid && r.need_link && (link_page == r.boundary))
        begin
          // never link into the host's read pointer page; a frame that starts on that page is not checked
          next_r.state = rxbm_pkg::RXBM_DROP;
          next_r.overflow = 1'b1;
        end
        else if (i_rx_valid)
        begin
          // every byte the mac delivers, check sequence included, goes to memory
          next_r.length = r.length + 11'h001;
          if (r.need_link)
          begin
            next_r.cur_page = link_page;
            next_r.need_link = 1'b0;
          end
          next_r.offset = r.offset + 8'h01;
          if (r.offset == 8'hff)
          begin
            next_r.need_link = 1'b1;
          end
          if (r.have_low)
          begin
            next_r.mem_we = 1'b1;
            next_r.mem_addr = word_of(r.need_link ? link_page : r.cur_page, r.offset);
            next_r.mem_wdata = {i_rx_data, r.low_byte};
            next_r.have_low = 1'b0;
          end
          else
          begin
            next_r.low_byte = i_rx_data;
            next_r.have_low = 1'b1;
          end
        end
        else if (i_rx_end)
        begin
          // odd trailing byte goes out padded; rest of the page stays unused
          if (r.have_low)
          begin
            next_r.mem_we = 1'b1;
            next_r.mem_addr = word_of(r.cur_page, r.offset - 8'h01);
            next_r.mem_wdata = {8'h00, r.low_byte};
            next_r.have_low = 1'b0;
          end
          next_r.hdr_status = stat_byte;
          next_r.last_status = stat_byte;
          if (reject)
          begin
            // write pointer untouched, so every page of the frame is reclaimed
            next_r.state = rxbm_pkg::RXBM_IDLE;
            next_r.dropped = 1'b1;
          end
          else
          begin
            next_r.state = rxbm_pkg::RXBM_HDR0;
          end
        end
      end
      rxbm_pkg::RXBM_DROP:
      begin
        if (i_rx_end)
        begin
          next_r.state = rxbm_pkg::RXBM_IDLE;
          next_r.dropped = 1'b1;
        end
      end
      rxbm_pkg::RXBM_HDR0:
      begin
        // back to the frame's first page for the header
        next_r.mem_we = 1'b1;
        next_r.mem_addr = word_of(r.rx_write_page_ptr, 8'h00);
        next_r.mem_wdata = {r.following_frame_page, r.hdr_status};
        next_r.state = rxbm_pkg::RXBM_HDR1;
      end
      rxbm_pkg::RXBM_HDR1:
      begin
        next_r.mem_we = 1'b1;
        next_r.mem_addr = word_of(r.rx_write_page_ptr, 8'h02);
        next_r.mem_wdata = {5'h00, r.length};
        next_r.rx_write_page_ptr = r.following_frame_page;
        next_r.done = 1'b1;
        next_r.state = rxbm_pkg::RXBM_IDLE;
      end
      default:
      begin
        next_r.state = rxbm_pkg::RXBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r <= '0;
      r.state <= rxbm_pkg::RXBM_IDLE;
      r.ring_first <= `RXBM_RST_RING_FIRST;
      r.ring_end <= `RXBM_RST_RING_END;
      r.rx_write_page_ptr <= `RXBM_RST_WRITE_PTR;
      r.boundary <= `RXBM_RST_BOUNDARY;
      {r.acc_err, r.acc_runt} <= `RXBM_RST_CONFIG;
    end
    else
    begin
      r <= next_r;
    end
  end

  // header cycles hold off a new frame start
  assign o_rx_ready = (r.state == rxbm_pkg::RXBM_IDLE) || (r.state == rxbm_pkg::RXBM_RECV) ||
                      (r.state == rxbm_pkg::RXBM_DROP);
  assign o_reg_rdata = r.rdata;
  assign o_frame_done = r.done;
  assign o_frame_dropped = r.dropped;

  // local dma write port plus host read port of the packet memory
  rxbm_mem #(
    .WORDS(`RXBM_MEM_WORDS),
    .AW(AW)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(r.mem_we),
    .i_waddr(r.mem_addr),
    .i_wdata(r.mem_wdata),
    .i_re(i_host_rd),
    .i_raddr(i_host_word_addr),
    .o_rdata(o_host_rdata)
  );

endmodule : rxbm_ring

`default_nettype wire

// file: tb/rxbm_ring_sva.sv
// port checker for the receive ring manager
// assumes binding to rxbm_ring, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none

module rxbm_ring_sva (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register read side
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // receive stream and events
  input wire logic i_rx_start,
  input wire logic i_rx_end,
  input wire logic o_rx_ready,
  input wire logic o_frame_done,
  input wire logic o_frame_dropped
);
  logic in_frame;
  logic fin;

  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  // end pulses outside a frame are ignored by the block, so only these count
  assign fin = in_frame && i_rx_end;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      in_frame <= 1'b0;
    else if (i_rx_end)
      in_frame <= 1'b0;
    else if (i_rx_start && o_rx_ready)
      in_frame <= 1'b1;
  end

  a_end_resolves: assert property (fin |=> (!o_rx_ready != o_frame_dropped))
    else $error("frame end neither headed nor dropped");
  a_hdr_two: assert property ($fell(o_rx_ready) |=> !o_rx_ready ##1 (o_rx_ready && o_frame_done))
    else $error("header phase not two cycles then done");
  a_ready_cause: assert property (!o_rx_ready |-> $past(fin) || !$past(o_rx_ready))
    else $error("ready low without a frame end");
  a_done_cause: assert property (o_frame_done |-> $past(fin, 3))
    else $error("done not three cycles after end");
  a_drop_cause: assert property (o_frame_dropped |-> $past(fin))
    else $error("drop not one cycle after end");
  a_done_excl: assert property (!(o_frame_done && o_frame_dropped))
    else $error("done and drop together");
  a_done_single: assert property (o_frame_done |=> !o_frame_done)
    else $error("done longer than one cycle");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : rxbm_ring_sva

bind rxbm_ring rxbm_ring_sva u_sva (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_rx_start(i_rx_start), .i_rx_end(i_rx_end), .o_rx_ready(o_rx_ready),
  .o_frame_done(o_frame_done), .o_frame_dropped(o_frame_dropped));

`default_nettype wire

// file: tb/rxbm_mac_model.sv
// frame source standing in for the mac receive logic
// assumes the bench waits for each frame outcome before the next start
`timescale 1ns/1ps
`default_nettype none

module rxbm_mac_model (
  // clock
  input wire logic i_sys_clk,
  // receive stream
  output logic o_start,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_end,
  // {mcast, runt, mii, align, crc}
  output logic [4:0] o_flags
);
  initial
  begin
    o_start = 1'b0;
    o_valid = 1'b0;
    o_data = 8'h00;
    o_end = 1'b0;
    o_flags = 5'h00;
  end

  // last four of n bytes stand for the check sequence; gap idles between bytes
  task send(input int n, input logic [4:0] fl, input int gap);
    int i;
    @(posedge i_sys_clk);
    o_start <= 1'b1;
    for (i = 0; i < n; i++)
    begin
      @(posedge i_sys_clk);
      o_start <= 1'b0;
      o_valid <= 1'b1;
      o_data <= i[7:0] + 8'h30;
      repeat (gap)
      begin
        @(posedge i_sys_clk);
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    o_data <= ~o_data;
    o_end <= 1'b1;
    o_flags <= fl;
    @(posedge i_sys_clk);
    o_end <= 1'b0;
    o_flags <= 5'h00;
  endtask : send
endmodule : rxbm_mac_model

`default_nettype wire

// file: tb/test_rxbm_ring.sv
// self-checking bench for the receive ring manager
// assumes the mac model as frame source and the host read port for memory checks
`timescale 1ns/1ps
`default_nettype none
`include "rxbm_map.svh"

module test_rxbm_ring;
  logic clk, rstn, wr, rd, hrd, start, valid, fend, ready, done, drop;
  logic [2:0] addr;
  logic [7:0] wdat, rdat, data;
  logic [4:0] fl;
  logic [12:0] haddr;
  logic [15:0] hdat;
  logic [4:0] rej [3] = '{5'h01, 5'h02, 5'h08};
  int err_count, num_checks, i;

  rxbm_ring dut (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdat), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdat), .i_rx_start(start), .i_rx_valid(valid), .i_rx_data(data),
    .i_rx_end(fend), .i_rx_runt(fl[3]), .i_rx_crc_err(fl[0]), .i_rx_align_err(fl[1]), .i_rx_mii_err(fl[2]),
    .i_rx_mcast(fl[4]), .o_rx_ready(ready), .i_host_rd(hrd), .i_host_word_addr(haddr), .o_host_rdata(hdat),
    .o_frame_done(done), .o_frame_dropped(drop));
  rxbm_mac_model mac (.i_sys_clk(clk), .o_start(start), .o_valid(valid), .o_data(data), .o_end(fend), .o_flags(fl));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task summarize;
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : rwr

  task rrd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdat}, {8'h00, e});
  endtask : rrd

  task mrd(input logic [12:0] a, input logic [15:0] e);
    @(posedge clk);
    haddr <= a;
    hrd <= 1'b1;
    @(posedge clk);
    hrd <= 1'b0;
    #1 chk(hdat, e);
  endtask : mrd

  function automatic logic [7:0] bv(input int k);
    return k[7:0] + 8'h30;
  endfunction : bv

  // ev is {done, dropped}
  task frame(input int n, input logic [4:0] f, input int gap, input logic [1:0] ev);
    int k;
    logic hdr_busy;
    mac.send(n, f, gap);
    k = 0;
    // send returns in the edge that samples the end pulse; a drop pulse stands right after it
    #1;
    hdr_busy = !ready;
    while (!(done || drop) && k < 40)
    begin
      @(posedge clk);
      #1 k++;
      hdr_busy = hdr_busy | !ready;
    end
    chk({14'h0, done, drop}, {14'h0, ev});
    chk({15'h0, hdr_busy}, {15'h0, ev[1]});
  endtask : frame

  task hdr(input logic [7:0] p, input logic [7:0] nx, input logic [7:0] st, input int n);
    logic [12:0] b;
    int k;
    b = {p[5:0], 7'h00};
    mrd(b, {nx, st});
    mrd(b + 13'h1, {5'h00, n[10:0]});
    for (k = 0; k < n && k < 8; k += 2)
      mrd(b + 13'(2 + k / 2), {(k + 1 < n) ? bv(k + 1) : 8'h00, bv(k)});
  endtask : hdr

  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    hrd = 1'b0;
    addr = 3'h0;
    wdat = 8'h00;
    haddr = 13'h0;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rrd(3'h0, `RXBM_RST_RING_FIRST);
    rrd(3'h1, `RXBM_RST_RING_END);
    rrd(3'h2, `RXBM_RST_WRITE_PTR);
    rrd(3'h3, `RXBM_RST_BOUNDARY);
    rwr(3'h7, 8'hff);
    rrd(3'h7, 8'h00);
    rwr(3'h0, 8'h10);
    rwr(3'h1, 8'h13);
    rwr(3'h2, 8'h10);
    rwr(3'h3, 8'h12);
    rrd(3'h1, 8'h13);
    frame(6, 5'h00, 0, 2'b10);
    rrd(3'h2, 8'h11);
    hdr(8'h10, 8'h11, 8'h01, 6);
    frame(7, 5'h14, 1, 2'b10);
    rrd(3'h6, 8'h28);
    hdr(8'h11, 8'h12, 8'h28, 7);
    for (i = 0; i < 3; i++)
    begin
      frame(5, rej[i], 0, 2'b01);
      rrd(3'h2, 8'h12);
    end
    rwr(3'h4, 8'h03);
    frame(5, 5'h0b, 0, 2'b10);
    hdr(8'h12, 8'h10, 8'h16, 5);
    rwr(3'h4, 8'h00);
    frame(300, 5'h00, 0, 2'b10);
    hdr(8'h10, 8'h12, 8'h01, 300);
    mrd(13'h880, {bv(253), bv(252)});
    rwr(3'h3, 8'h11);
    frame(300, 5'h00, 0, 2'b10);
    hdr(8'h12, 8'h11, 8'h01, 300);
    mrd(13'h800, {bv(253), bv(252)});
    rwr(3'h3, 8'h12);
    frame(300, 5'h00, 0, 2'b01);
    rrd(3'h5, 8'h01);
    rrd(3'h2, 8'h11);
    mrd(13'h900, {8'h11, 8'h01});
    rwr(3'h5, 8'h01);
    rrd(3'h5, 8'h00);
    rwr(3'h0, 8'h20);
    rwr(3'h1, 8'h30);
    rwr(3'h2, 8'h20);
    rwr(3'h3, 8'h2f);
    frame(1522, 5'h00, 0, 2'b10);
    rrd(3'h2, 8'h26);
    mrd(13'h12fa, {bv(1521), bv(1520)});
    summarize();
  end

  // whole run is about 2600 cycles
  initial
  begin
    repeat (8000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule : test_rxbm_ring

`default_nettype wire
